// File: rtl/pciu_consts.vh
// Constants for the pin change interrupt unit
//
// Contract
// - Detect changes on ports A,B,C and E[3:0]
// - Every pin individually configurable
// - Rising detector only when rising enable set
// - Falling detector only when falling enable set
// - Both enables detect both edges
// - Enabled edge sets pin change flag
// - Flags always set; irq gated by enable
// - Summary flag is OR of all flags
// - Writing zero clears a flag bit
// - Edge during flag write leaves flag set
// - Change event wakes from Sleep if enabled
`ifndef PCIU_CONSTS_VH
`define PCIU_CONSTS_VH

`define PCIU_PORT_COUNT        4
`define PCIU_PORT_IDX_W        2
`define PCIU_PORT_E_MASK       8'h0F
`define PCIU_FULL_MASK         8'hFF
`define PCIU_REG_RESET         8'h00
// Register map: port p at block base 16*p, three words each
`define PCIU_ADDR_W            8
`define PCIU_PORT_STRIDE_SH    4
`define PCIU_OFF_RISE          4'h0
`define PCIU_OFF_FALL          4'h4
`define PCIU_OFF_FLAG          4'h8
`define PCIU_ADDR_CTRL         8'h40
`define PCIU_ADDR_STAT         8'h44
`define PCIU_CTRL_IRQ_EN_BIT   0
`define PCIU_STAT_SUMMARY_BIT  0
`define PCIU_STAT_WAKE_BIT     1

`endif

// File: rtl/pciu_sync.v
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module pciu_sync #(
   parameter WIDTH = 8
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // pciu_sync
`default_nettype wire

// File: rtl/pciu_port.v
// One port's edge detectors, enables and change flags
`include "pciu_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module pciu_port #(
   parameter [7:0] PIN_MASK = 8'hFF
) (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [7:0] pin_sync,
   input  wire       wr_rise,
   input  wire       wr_fall,
   input  wire       wr_flag,
   input  wire [7:0] wdata,
   output reg  [7:0] rise_q,
   output reg  [7:0] fall_q,
   output reg  [7:0] flag_q
);
   reg  [7:0] prev_q;
   reg  [2:0] primed_q;
   wire [7:0] edge_hit;
   reg  [7:0] flag_d;

   // Compare synchronised level with last sample
   // Three priming edges: sync flops and last sample must hold real levels,
   // else a pin idling high looks like a rising edge after reset
   assign edge_hit = primed_q[2] ? (((pin_sync & ~prev_q) & rise_q)
                              | ((~pin_sync & prev_q) & fall_q)) & PIN_MASK
                             : 8'h00;

   always @* begin
      flag_d = flag_q;
      if (wr_flag)
         flag_d = flag_q & wdata & PIN_MASK;
      flag_d = flag_d | edge_hit;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_q   <= `PCIU_REG_RESET;
         fall_q   <= `PCIU_REG_RESET;
         flag_q   <= `PCIU_REG_RESET;
         prev_q   <= `PCIU_REG_RESET;
         primed_q <= 3'b000;
      end else begin
         prev_q   <= pin_sync;
         primed_q <= {primed_q[1:0], 1'b1};
         if (wr_rise)
            rise_q <= wdata & PIN_MASK;
         if (wr_fall)
            fall_q <= wdata & PIN_MASK;
         flag_q <= flag_d;
      end
   end
endmodule // pciu_port
`default_nettype wire

// File: rtl/pciu_top.v
// Pin change interrupt unit: APB slave, four ports, irq and wake
`include "pciu_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module pciu_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [7:0]  port_a_pins,
   input  wire [7:0]  port_b_pins,
   input  wire [7:0]  port_c_pins,
   input  wire [3:0]  port_e_a_pins,
   input  wire        sleeping,
   output reg         pin_change_interrupt_req,
   output reg         change_irq_summary_flag,
   output reg         wake_req
);
   wire [31:0] pins_raw;
   wire [31:0] pins_sync;
   wire [31:0] rise_all;
   wire [31:0] fall_all;
   wire [31:0] flag_all;
   reg         change_irq_enable_q;
   reg         wake_seen_q;
   reg  [31:0] rdata_d;
   reg         err_d;
   wire        setup;
   wire        wr_go;
   wire [1:0]  port_sel;
   wire [3:0]  reg_off;
   wire        in_ports;
   wire [`PCIU_PORT_COUNT-1:0] wr_rise;
   wire [`PCIU_PORT_COUNT-1:0] wr_fall;
   wire [`PCIU_PORT_COUNT-1:0] wr_flag;

   // Unused upper bits of port E tied low
   assign pins_raw = {4'h0, port_e_a_pins, port_c_pins, port_b_pins, port_a_pins};

   pciu_sync #(.WIDTH(32)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   // Access phase answered in one cycle; pready low elsewhere
   assign setup    = psel && !penable;
   assign wr_go    = psel && penable && pwrite && pready;
   assign port_sel = paddr[5:4];
   assign reg_off  = paddr[3:0];
   assign in_ports = (paddr[31:6] == 26'h0000000);

   function is_hit;
      input [3:0] off;
      input [3:0] want;
      begin
         is_hit = (off == want);
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < `PCIU_PORT_COUNT; g = g + 1) begin : g_port
         assign wr_rise[g] = wr_go && in_ports && ({30'h0, port_sel} == g)
                             && is_hit(reg_off, `PCIU_OFF_RISE);
         assign wr_fall[g] = wr_go && in_ports && ({30'h0, port_sel} == g)
                             && is_hit(reg_off, `PCIU_OFF_FALL);
         assign wr_flag[g] = wr_go && in_ports && ({30'h0, port_sel} == g)
                             && is_hit(reg_off, `PCIU_OFF_FLAG);
         pciu_port #(
            .PIN_MASK ((g == 3) ? `PCIU_PORT_E_MASK : `PCIU_FULL_MASK)
         ) u_port (
            .pclk     (pclk),
            .presetn  (presetn),
            .pin_sync (pins_sync[8*g+7:8*g]),
            .wr_rise  (wr_rise[g]),
            .wr_fall  (wr_fall[g]),
            .wr_flag  (wr_flag[g]),
            .wdata    (pwdata[7:0]),
            .rise_q   (rise_all[8*g+7:8*g]),
            .fall_q   (fall_all[8*g+7:8*g]),
            .flag_q   (flag_all[8*g+7:8*g])
         );
      end
   endgenerate

   // Read mux and unmapped-address error
   always @* begin
      rdata_d = 32'h00000000;
      err_d   = 1'b0;
      if (in_ports && is_hit(reg_off, `PCIU_OFF_RISE))
         rdata_d = {24'h000000, rise_all[8*port_sel +: 8]};
      else if (in_ports && is_hit(reg_off, `PCIU_OFF_FALL))
         rdata_d = {24'h000000, fall_all[8*port_sel +: 8]};
      else if (in_ports && is_hit(reg_off, `PCIU_OFF_FLAG))
         rdata_d = {24'h000000, flag_all[8*port_sel +: 8]};
      else if (paddr == {24'h000000, `PCIU_ADDR_CTRL})
         rdata_d[`PCIU_CTRL_IRQ_EN_BIT] = change_irq_enable_q;
      else if (paddr == {24'h000000, `PCIU_ADDR_STAT}) begin
         rdata_d[`PCIU_STAT_SUMMARY_BIT] = change_irq_summary_flag;
         rdata_d[`PCIU_STAT_WAKE_BIT]    = wake_seen_q;
      end else
         err_d = 1'b1;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready                   <= 1'b0;
         pslverr                  <= 1'b0;
         prdata                   <= 32'h00000000;
         change_irq_enable_q      <= 1'b0;
         change_irq_summary_flag  <= 1'b0;
         pin_change_interrupt_req <= 1'b0;
         wake_req                 <= 1'b0;
         wake_seen_q              <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && err_d;
         if (setup && !pwrite)
            prdata <= rdata_d;
         if (wr_go && paddr == {24'h000000, `PCIU_ADDR_CTRL})
            change_irq_enable_q <= pwdata[`PCIU_CTRL_IRQ_EN_BIT];
         change_irq_summary_flag  <= |flag_all;
         pin_change_interrupt_req <= (|flag_all) && change_irq_enable_q;
         wake_req <= sleeping && (|flag_all) && change_irq_enable_q;
         // Sticky record of a wake; cleared by writing one, set wins
         if (sleeping && (|flag_all) && change_irq_enable_q)
            wake_seen_q <= 1'b1;
         else if (wr_go && paddr == {24'h000000, `PCIU_ADDR_STAT}
                  && pwdata[`PCIU_STAT_WAKE_BIT])
            wake_seen_q <= 1'b0;
      end
   end
endmodule // pciu_top
`default_nettype wire

// File: bench/pciu_monitor.sv
// Assertion checker for the pin change interrupt unit
`timescale 1ns/10ps
`default_nettype none
module pciu_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  port_a_pins,
   input wire logic [7:0]  port_b_pins,
   input wire logic [7:0]  port_c_pins,
   input wire logic [3:0]  port_e_a_pins,
   input wire logic        sleeping,
   input wire logic        pin_change_interrupt_req,
   input wire logic        change_irq_summary_flag,
   input wire logic        wake_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [27:0] pins;
   assign pins = {port_e_a_pins, port_c_pins, port_b_pins, port_a_pins};
   property p_rdy; pready |=> !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready held");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_up; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_up: assert property (p_up) else $error("upper read bits set");
   property p_pe; pready && !pwrite && paddr[7:4] == 4'h3 |-> prdata[7:4] == 4'h0; endproperty
   a_pe: assert property (p_pe) else $error("port e high bits set");
   property p_irq; pin_change_interrupt_req |-> change_irq_summary_flag; endproperty
   a_irq: assert property (p_irq) else $error("irq without flag");
   property p_wake; wake_req |-> $past(sleeping) && pin_change_interrupt_req; endproperty
   a_wake: assert property (p_wake) else $error("wake without cause");
   property p_set; $rose(change_irq_summary_flag) |-> $past(pins, 2) != $past(pins, 6); endproperty
   a_set: assert property (p_set) else $error("flag set without edge");
   property p_clr;
      $fell(change_irq_summary_flag) |-> $past(psel && penable && pwrite && pready, 2);
   endproperty
   a_clr: assert property (p_clr) else $error("flag cleared without write");
   c_irq: cover property ($rose(pin_change_interrupt_req));
   c_wake: cover property ($rose(wake_req));
   c_err: cover property (pslverr);
endmodule // pciu_monitor
bind pciu_top pciu_monitor u_pciu_monitor (.*);
`default_nettype wire

// File: bench/pciu_pin_model.sv
// External signal source for the port pins
`timescale 1ns/10ps
`default_nettype none
module pciu_pin_model (
   input  wire logic        pclk,
   input  wire logic [27:0] want,
   output var  logic [7:0]  port_a_pins,
   output var  logic [7:0]  port_b_pins,
   output var  logic [7:0]  port_c_pins,
   output var  logic [3:0]  port_e_a_pins
);
   // Levels move just after an edge, so each is held at least one clock
   initial {port_e_a_pins, port_c_pins, port_b_pins, port_a_pins} = 28'h0;
   always @(posedge pclk) {port_e_a_pins, port_c_pins, port_b_pins, port_a_pins} <= want;
endmodule // pciu_pin_model
`default_nettype wire

// File: bench/test_pin_change_interrupt_unit.sv
// Self-checking bench for the pin change interrupt unit
`timescale 1ns/10ps
`default_nettype none
module test_pin_change_interrupt_unit;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleeping = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, r;
   logic        pready, pslverr, irq, summ, wake, e;
   logic [7:0]  pa, pb, pc;
   logic [3:0]  pe;
   logic [27:0] want = 0;
   int          n_fail = 0, n_tests = 0;
   always #5 pclk = ~pclk;
   pciu_pin_model u_pciu_pin_model (.pclk(pclk), .want(want), .port_a_pins(pa),
      .port_b_pins(pb), .port_c_pins(pc), .port_e_a_pins(pe));
   pciu_top u_pciu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
      .port_e_a_pins(pe), .sleeping(sleeping), .pin_change_interrupt_req(irq),
      .change_irq_summary_flag(summ), .wake_req(wake));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reads each flag register, then clears only the bits seen set
   task automatic clear(input logic [7:0] exp);
      logic [7:0] m;
      for (int p = 0; p < 4; p++) begin
         m = (p == 3) ? 8'h0F : 8'hFF;
         apb(1'b0, 8'(p * 16 + 8), 0);
         chk("flag", r, {24'h0, exp & m});
         apb(1'b1, 8'(p * 16 + 8), ~r);
      end
      repeat (2) @(posedge pclk);
      #1;
      chk("summary clear", summ, 1'b0);
   endtask
   initial begin
      #200000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      for (int p = 0; p < 4; p++) begin
         apb(1'b0, 8'(p * 16), 0);
         chk("rise reset", r, 0);
         apb(1'b1, 8'(p * 16), 32'hF5);
         apb(1'b1, 8'(p * 16 + 4), 32'h06);
         apb(1'b0, 8'(p * 16), 0);
         chk("rise enable", r, (p == 3) ? 32'h05 : 32'hF5);
      end
      $display("test config done");
      want <= 28'hFFFFFFF;
      repeat (8) @(posedge pclk);
      #1;
      chk("summary", summ, 1'b1);
      chk("irq masked", irq, 1'b0);
      clear(8'hF5);
      apb(1'b1, 8'h40, 32'h1);
      want <= 28'h0;
      sleeping <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk("irq", irq, 1'b1);
      chk("wake", wake, 1'b1);
      apb(1'b0, 8'h44, 0);
      chk("status", r, 32'h3);
      apb(1'b0, 8'h40, 0);
      chk("irq enable", r, 32'h1);
      apb(1'b1, 8'h08, 32'hFF);
      clear(8'h06);
      chk("wake idle", wake, 1'b0);
      apb(1'b1, 8'h44, 32'h2);
      apb(1'b0, 8'h44, 0);
      chk("wake seen clear", r, 0);
      sleeping <= 1'b0;
      $display("test edges done");
      apb(1'b1, 8'h80, 32'hFF);
      chk("unmapped err", e, 1'b1);
      apb(1'b0, 8'h80, 0);
      chk("unmapped data", r, 0);
      $display("test unmapped done");
      report_and_stop;
   end
endmodule // test_pin_change_interrupt_unit
`default_nettype wire
